// [spm_pkg.sv]
/*
 Constants, register map and carrier types for the status pin monitor block.
 Assumes one 200 MHz system clock and APB register access.
*/
package spm_pkg;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [11:0] SPM_IDX_MON_FIRST = 12'h505;
    localparam logic [11:0] SPM_IDX_MON_SECOND = 12'h506;
    localparam logic [11:0] SPM_IDX_CTRL = 12'h507;
    localparam logic [11:0] SPM_IDX_STATE = 12'h50a;

    // Fields of status_pin_output_control
    localparam int SPM_CTRL_DIV_SECOND = 0;
    localparam int SPM_CTRL_DIV_FIRST = 1;
    localparam int SPM_CTRL_OE_FIRST = 2;
    localparam int SPM_CTRL_OE_SECOND = 3;
    localparam logic [3:0] SPM_CTRL_MASK = 4'hf;

    // Reset values
    localparam logic [3:0] SPM_CTRL_RESET = 4'h0;
    localparam logic [5:0] SPM_SEL_RESET = 6'h00;

    // Source select code ranges
    localparam logic [5:0] SPM_SEL_STATIC_LAST = 6'h0f;
    localparam logic [5:0] SPM_SEL_PLL1_LAST = 6'h13;
    localparam logic [5:0] SPM_SEL_PLL2_FIRST = 6'h14;
    localparam logic [5:0] SPM_SEL_PLL2_REF = 6'h16;
    localparam logic [5:0] SPM_SEL_PLL2_UP = 6'h17;
    localparam logic [5:0] SPM_SEL_PLL1_UP = 6'h13;

    // Static status levels from the clock generator core
    typedef struct packed {
        logic fast_lock;
        logic pll2_fb_ok;
        logic pll1_fb_ok;
        logic vcxo_ok;
        logic holdover;
        logic ref_b_ok;
        logic ref_a_ok;
        logic ref_b_selected;
        logic refs_missing;
        logic pll2_locked;
        logic pll1_locked;
    } spm_flags_type;

    // Dynamic clocks of one PLL; bit order matches the low two select bits
    typedef struct packed {
        logic pfd_up;
        logic ref_clk;
        logic pfd_down;
        logic feedback;
    } spm_dyn_type;

endpackage : spm_pkg

// [spm_status_mux.sv]
/*
 Status pin monitor: two source multiplexers, divide-by-4 stages and output
 enables for the two status pins, with APB access to the select and control
 registers. Assumes status flags and PLL clocks arrive asynchronously and
 are much slower than sys_clk.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module spm_status_mux import spm_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status sources
    input wire spm_flags_type flags_in,
    input wire spm_dyn_type pll1_dyn_in,
    input wire spm_dyn_type pll2_dyn_in,
    // Status pins
    output logic status_pin_first_o,
    output logic status_pin_first_oe,
    output logic status_pin_second_o,
    output logic status_pin_second_oe
);

    localparam int NSRC = $bits(spm_flags_type) + 8;

    logic [NSRC-1:0] sync1_q, sync2_q;
    spm_flags_type flags;
    logic [7:0] dyn_sync, dyn_last_q, dyn_half_q;
    logic [5:0] sel_first_q, sel_second_q;
    logic [3:0] ctrl_q;
    logic mon_first, mon_second, mon_first_last_q, mon_second_last_q;
    logic [1:0] div_first_q, div_second_q;
    logic access, ack;
    logic [11:0] idx;

    // Two-flop synchronisers for every asynchronous source
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {pll2_dyn_in, pll1_dyn_in, flags_in};
            sync2_q <= sync1_q;
        end
    end

    assign flags = spm_flags_type'(sync2_q[$bits(spm_flags_type)-1:0]);
    assign dyn_sync = sync2_q[NSRC-1:$bits(spm_flags_type)];

    // Divide-by-2 of each PLL clock: toggle on every synchronised rising edge
    generate
        for (genvar i = 0; i < 8; i++) begin : g_half
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    dyn_last_q[i] <= 1'b0;
                    dyn_half_q[i] <= 1'b0;
                end else begin
                    dyn_last_q[i] <= dyn_sync[i];
                    if (dyn_sync[i] && !dyn_last_q[i]) begin
                        dyn_half_q[i] <= ~dyn_half_q[i];
                    end
                end
            end
        end
    endgenerate

    function automatic logic mon_select(input logic [5:0] code, input logic second,
                                        input spm_flags_type f, input logic [7:0] half);
        logic r;
        r = 1'b0;
        if (code <= SPM_SEL_STATIC_LAST) begin
            case (code[3:0])
                4'h1: r = f.pll1_locked & f.pll2_locked;
                4'h2: r = f.pll1_locked;
                4'h3: r = f.pll2_locked;
                4'h4: r = f.refs_missing;
                4'h5: r = f.refs_missing & f.pll2_locked;
                4'h6: r = f.ref_b_selected;
                4'h7: r = f.ref_a_ok;
                4'h8: r = f.ref_b_ok;
                4'h9: r = f.holdover;
                4'ha: r = f.vcxo_ok;
                4'hb: r = f.pll1_fb_ok;
                4'hc: r = f.pll2_fb_ok;
                4'hd: r = f.fast_lock;
                4'he: r = f.ref_a_ok & f.ref_b_ok;
                4'hf: r = f.ref_a_ok & f.ref_b_ok & f.vcxo_ok & f.pll1_fb_ok & f.pll2_fb_ok;
                default: r = 1'b0;
            endcase
        end else if (code <= SPM_SEL_PLL1_LAST) begin
            r = !second && half[code[1:0]];
        end else if (code <= SPM_SEL_PLL2_UP) begin
            r = second && half[{1'b1, code[1:0]}];
        end else begin
            r = 1'b0;
        end
        return r;
    endfunction : mon_select

    assign mon_first = mon_select(sel_first_q, 1'b0, flags, dyn_half_q);
    assign mon_second = mon_select(sel_second_q, 1'b1, flags, dyn_half_q);

    // Divide-by-4: two-bit count of monitor rising edges, top bit is output
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mon_first_last_q <= 1'b0;
            mon_second_last_q <= 1'b0;
            div_first_q <= 2'h0;
            div_second_q <= 2'h0;
        end else begin
            mon_first_last_q <= mon_first;
            mon_second_last_q <= mon_second;
            if (mon_first && !mon_first_last_q) begin
                div_first_q <= div_first_q + 2'h1;
            end
            if (mon_second && !mon_second_last_q) begin
                div_second_q <= div_second_q + 2'h1;
            end
        end
    end

    // Pin drivers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_pin_first_o <= 1'b0;
            status_pin_second_o <= 1'b0;
            status_pin_first_oe <= 1'b0;
            status_pin_second_oe <= 1'b0;
        end else begin
            status_pin_first_o <= ctrl_q[SPM_CTRL_DIV_FIRST] ? div_first_q[1] : mon_first;
            status_pin_second_o <= ctrl_q[SPM_CTRL_DIV_SECOND] ? div_second_q[1] : mon_second;
            status_pin_first_oe <= ctrl_q[SPM_CTRL_OE_FIRST];
            status_pin_second_oe <= ctrl_q[SPM_CTRL_OE_SECOND];
        end
    end

    // APB: one wait state, answer in the second access cycle
    assign access = psel && penable && !pready;
    assign ack = psel && penable && pready;
    assign idx = paddr[13:2];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (access) begin
                case (idx)
                    SPM_IDX_MON_FIRST: prdata <= {26'h0, sel_first_q};
                    SPM_IDX_MON_SECOND: prdata <= {26'h0, sel_second_q};
                    SPM_IDX_CTRL: prdata <= {28'h0, ctrl_q};
                    SPM_IDX_STATE: prdata <= {28'h0, status_pin_second_o, status_pin_first_o,
                                              mon_second, mon_first};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Writes take effect at the completing edge; the state register is read-only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sel_first_q <= SPM_SEL_RESET;
            sel_second_q <= SPM_SEL_RESET;
            ctrl_q <= SPM_CTRL_RESET;
        end else if (ack && pwrite) begin
            case (idx)
                SPM_IDX_MON_FIRST: sel_first_q <= pwdata[5:0];
                SPM_IDX_MON_SECOND: sel_second_q <= pwdata[5:0];
                SPM_IDX_CTRL: ctrl_q <= pwdata[3:0] & SPM_CTRL_MASK;
                default: ;
            endcase
        end
    end

    // Checks
    pll2_ref_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        sel_second_q == SPM_SEL_PLL2_REF |-> mon_second == dyn_half_q[6])
        else $error("second monitor not PLL2 reference half rate");
    pll2_up_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        sel_second_q == SPM_SEL_PLL2_UP |-> mon_second == dyn_half_q[7])
        else $error("second monitor not PLL2 up pulse half rate");
    pin_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(ctrl_q[SPM_CTRL_OE_FIRST]) |=> !status_pin_first_oe [*2])
        else $error("first pin driven while disabled");
    second_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1 |=> status_pin_second_oe == $past(ctrl_q[SPM_CTRL_OE_SECOND]))
        else $error("second pin enable does not follow its control bit");
    first_div_a: assert property (@(posedge sys_clk) disable iff (rst)
        ctrl_q[SPM_CTRL_DIV_FIRST] && $stable(div_first_q) && $stable(ctrl_q)
        |=> $stable(status_pin_first_o))
        else $error("divided first pin moved without a count step");
    second_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrl_q[SPM_CTRL_DIV_SECOND] |=> status_pin_second_o == $past(mon_second))
        else $error("undivided second pin differs from its source");
    static_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
        sel_first_q == 6'h01 |-> mon_first == (flags.pll1_locked && flags.pll2_locked))
        else $error("combined lock level wrong");
    pll1_up_a: assert property (@(posedge sys_clk) disable iff (rst)
        sel_first_q == SPM_SEL_PLL1_UP |-> mon_first == dyn_half_q[3])
        else $error("first monitor not PLL1 up pulse half rate");
    reserved_low_a: assert property (@(posedge sys_clk) disable iff (rst)
        sel_first_q > SPM_SEL_PLL2_UP || sel_second_q > SPM_SEL_PLL2_UP
        |-> !(sel_first_q > SPM_SEL_PLL2_UP && mon_first) && !(sel_second_q > SPM_SEL_PLL2_UP && mon_second))
        else $error("reserved code not low");

    div_used_c: cover property (@(posedge sys_clk) disable iff (rst)
        ctrl_q[SPM_CTRL_DIV_FIRST] && $rose(status_pin_first_o));
    pll2_view_c: cover property (@(posedge sys_clk) disable iff (rst)
        sel_second_q == SPM_SEL_PLL2_REF && $rose(status_pin_second_o));
    bad_addr_c: cover property (@(posedge sys_clk) disable iff (rst) pready && pslverr);

endmodule : spm_status_mux

`default_nettype wire

// [spm_status_mux_tb.sv]
/*
 Self-checking bench for the status pin monitor: register access, pin enables,
 static status levels, divide-by-2 clocks and divide-by-4 stages.
 Assumes the one-wait-state APB answer and sources slower than sys_clk/4.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module spm_status_mux_tb import spm_pkg::*; ();
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic err;
    spm_flags_type flags_in = '0;
    spm_dyn_type pll1_dyn_in = '0, pll2_dyn_in = '0;
    logic pin1_o, pin1_oe, pin2_o, pin2_oe, p1_q, p2_q;
    int num_errors = 0, n_compared = 0, tog1 = 0, tog2 = 0;

    always #2.5 sys_clk = ~sys_clk;

    spm_status_mux i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flags_in(flags_in), .pll1_dyn_in(pll1_dyn_in), .pll2_dyn_in(pll2_dyn_in),
        .status_pin_first_o(pin1_o), .status_pin_first_oe(pin1_oe),
        .status_pin_second_o(pin2_o), .status_pin_second_oe(pin2_oe));

    // Pin transition counters; phase-independent way to see division ratios
    always @(posedge sys_clk) begin
        if (pin1_o !== p1_q) tog1++;
        if (pin2_o !== p2_q) tog2++;
        p1_q = pin1_o;
        p2_q = pin2_o;
    end

    task give_verdict();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            num_errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task src_edges(input logic second, input int b, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            if (second) pll2_dyn_in[b] <= 1'h1; else pll1_dyn_in[b] <= 1'h1;
            repeat (4) @(posedge sys_clk);
            if (second) pll2_dyn_in[b] <= 1'h0; else pll1_dyn_in[b] <= 1'h0;
            repeat (4) @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
    endtask : src_edges

    task t_regs();
        apb(1'h0, SPM_IDX_CTRL, 32'h0);
        `CHK(rd, 32'h0)
        // Bits above the four control fields are dropped; both divide bits are written as 0
        apb(1'h1, SPM_IDX_CTRL, 32'hfc);
        apb(1'h0, SPM_IDX_CTRL, 32'h0);
        `CHK(rd, 32'hc)
        apb(1'h0, 12'h500, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'h1, SPM_IDX_CTRL, 32'h4);
        repeat (2) @(posedge sys_clk);
        `CHK({pin1_oe, pin2_oe}, 2'h2)
        apb(1'h1, SPM_IDX_CTRL, 32'h8);
        repeat (2) @(posedge sys_clk);
        `CHK({pin1_oe, pin2_oe}, 2'h1)
    endtask : t_regs

    // Static code, flag pattern and expected level of one step
    function automatic logic [17:0] st_step(input int i);
        logic [17:0] s;
        s = 18'h0;
        case (i)
            0: s = {6'h00, 11'h7ff, 1'h0};
            1: s = {6'h02, 11'h001, 1'h1};
            2: s = {6'h03, 11'h001, 1'h0};
            3: s = {6'h01, 11'h003, 1'h1};
            4: s = {6'h0d, 11'h400, 1'h1};
            5: s = {6'h09, 11'h040, 1'h1};
            6: s = {6'h04, 11'h004, 1'h1};
            7: s = {6'h05, 11'h004, 1'h0};
            8: s = {6'h06, 11'h008, 1'h1};
            9: s = {6'h07, 11'h020, 1'h0};
            10: s = {6'h08, 11'h020, 1'h1};
            11: s = {6'h0a, 11'h080, 1'h1};
            12: s = {6'h0b, 11'h200, 1'h0};
            13: s = {6'h0c, 11'h200, 1'h1};
            14: s = {6'h0e, 11'h010, 1'h0};
            default: s = 18'h0;
        endcase
        return s;
    endfunction : st_step

    task t_static();
        logic [17:0] s;
        apb(1'h1, SPM_IDX_CTRL, 32'hc);
        for (int i = 0; i < 15; i++) begin
            s = st_step(i);
            flags_in <= s[11:1];
            apb(1'h1, SPM_IDX_MON_FIRST, {26'h0, s[17:12]});
            apb(1'h1, SPM_IDX_MON_SECOND, {26'h0, s[17:12]});
            repeat (8) @(posedge sys_clk);
            `CHK({pin1_o, pin2_o}, {s[0], s[0]})
            apb(1'h0, SPM_IDX_STATE, 32'h0);
            `CHK(rd, {28'h0, {4{s[0]}}})
        end
    endtask : t_static

    // Same source edges give 8 pin changes at half rate and 2 after divide-by-4
    task t_dyn(input logic second, input logic [5:0] code, input int b, input logic [3:0] ctrl, input int exp);
        int t0;
        apb(1'h1, second ? SPM_IDX_MON_SECOND : SPM_IDX_MON_FIRST, {26'h0, code});
        apb(1'h1, SPM_IDX_CTRL, {28'h0, ctrl});
        repeat (8) @(posedge sys_clk);
        t0 = second ? tog2 : tog1;
        src_edges(second, b, 8);
        `CHK((second ? tog2 : tog1) - t0, exp)
    endtask : t_dyn

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'h0;
        t_regs();
        t_static();
        flags_in <= '0;
        t_dyn(1'h1, SPM_SEL_PLL2_REF, 2, 4'hc, 8);
        t_dyn(1'h1, SPM_SEL_PLL2_UP, 3, 4'hc, 8);
        t_dyn(1'h1, SPM_SEL_PLL2_REF, 2, 4'hd, 2);
        t_dyn(1'h0, SPM_SEL_PLL1_UP, 3, 4'hc, 8);
        t_dyn(1'h0, SPM_SEL_PLL1_UP, 3, 4'he, 2);
        t_dyn(1'h1, 6'h18, 2, 4'hc, 0);
        `CHK(pin2_o, 1'h0)
        give_verdict();
    end
endmodule : spm_status_mux_tb
`undef CHK
`default_nettype wire
